// ===== rtl/dp_host_pkg.sv
// Constants and types for the host end of one port of a two-port static memory
// with collision flags and token semaphores.
// Assumes a single 25 MHz clock; all pin timing is counted in its cycles.
package dp_host_pkg;

  localparam int ADDR_W      = 14;
  localparam int DATA_W      = 16;
  localparam int TOKEN_SEL_W = 3;
  localparam int CNT_W       = 4;

  localparam int CLK_PERIOD_NS               = 40;
  localparam int ACCESS_NS                   = 55;
  localparam int FLAG_SETTLE_NS              = 45;
  localparam int WRITE_HOLD_AFTER_RELEASE_NS = 25;
  localparam int SYNC_STAGES                 = 2;

  // Least times round up to whole cycles, never below one
  function automatic int ceil_cycles(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction

  localparam int ACCESS_CYC = ceil_cycles(ACCESS_NS);
  localparam int SETTLE_CYC = ceil_cycles(FLAG_SETTLE_NS) + SYNC_STAGES;
  localparam int HOLD_CYC   = ceil_cycles(WRITE_HOLD_AFTER_RELEASE_NS);
  localparam int READ_CYC   = ACCESS_CYC + SYNC_STAGES;

  localparam logic       FLAG_IDLE  = 1'h1;
  localparam logic [DATA_W-1:0] DATA_RST = 16'h0000;

  typedef enum logic [1:0] {
    OP_MEM_RD   = 2'h0,
    OP_MEM_WR   = 2'h1,
    OP_TOKEN_RD = 2'h2,
    OP_TOKEN_WR = 2'h3
  } op_t;

  typedef enum logic [5:0] {
    ST_IDLE      = 6'h01,
    ST_SETUP     = 6'h02,
    ST_STROBE    = 6'h04,
    ST_WAIT_FREE = 6'h08,
    ST_HOLD      = 6'h10,
    ST_DONE      = 6'h20
  } state_t;

endpackage

// ===== rtl/pin_sample_if.sv
// Carries raw pin levels to the sampler and the synchronised copies back.
// Assumes both ends run on the same clock.
`timescale 1ns/100ps
interface pin_sample_if;
  logic                           flag_raw;
  logic                           flag_sync;
  logic [dp_host_pkg::DATA_W-1:0] data_raw;
  logic [dp_host_pkg::DATA_W-1:0] data_sync;

  modport sampler (input flag_raw, input data_raw, output flag_sync, output data_sync);
  modport user    (output flag_raw, output data_raw, input flag_sync, input data_sync);
endinterface

// ===== rtl/pin_sampler.sv
// Two-stage synchronisers for the pins that the memory drives.
// Assumes pins are asynchronous to clock_i; the data word is only read once stable.
`timescale 1ns/100ps
module pin_sampler (
  input  wire logic         clock_i,
  input  wire logic         rst_b_i,
  pin_sample_if.sampler     smp
);
  logic                           flag_s1_ff;
  logic                           flag_s2_ff;
  logic [dp_host_pkg::DATA_W-1:0] data_s1_ff;
  logic [dp_host_pkg::DATA_W-1:0] data_s2_ff;

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      flag_s1_ff <= dp_host_pkg::FLAG_IDLE;
      flag_s2_ff <= dp_host_pkg::FLAG_IDLE;
    end else begin
      flag_s1_ff <= smp.flag_raw;
      flag_s2_ff <= flag_s1_ff;
    end
  end

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      data_s1_ff <= dp_host_pkg::DATA_RST;
      data_s2_ff <= dp_host_pkg::DATA_RST;
    end else begin
      data_s1_ff <= smp.data_raw;
      data_s2_ff <= data_s1_ff;
    end
  end

  assign smp.flag_sync = flag_s2_ff;
  assign smp.data_sync = data_s2_ff;
endmodule

// ===== rtl/dp_port_host.sv
// Host controller for one port of a two-port static memory: word reads and writes,
// semaphore reads and writes, and the collision flag pin in either device mode.
// Assumes the memory pins are asynchronous to clock_i and the user port is synchronous.
`timescale 1ns/100ps

module dp_port_host (
  input  wire logic                           clock_i,
  input  wire logic                           rst_b_i,
  input  wire logic                           cmd_valid_i,
  output logic                                cmd_ready_o,
  input  wire dp_host_pkg::op_t               cmd_op_i,
  input  wire logic [dp_host_pkg::ADDR_W-1:0] cmd_addr_i,
  input  wire logic [dp_host_pkg::DATA_W-1:0] cmd_wdata_i,
  input  wire logic                           slave_mode_i,
  input  wire logic                           write_block_i,
  output logic                                rsp_valid_o,
  output logic [dp_host_pkg::DATA_W-1:0]      rsp_rdata_o,
  output logic                                rsp_collided_o,
  output logic                                ce_n_o,
  output logic                                token_space_select_n_o,
  output logic                                rw_n_o,
  output logic                                oe_n_o,
  output logic [dp_host_pkg::ADDR_W-1:0]      addr_o,
  output logic [dp_host_pkg::DATA_W-1:0]      data_o,
  output logic                                data_oe_o,
  input  wire logic [dp_host_pkg::DATA_W-1:0] data_i,
  input  wire logic                           port_collision_flag_n_i,
  output logic                                port_collision_flag_n_o,
  output logic                                port_collision_flag_oe_o
);
  typedef logic [dp_host_pkg::CNT_W-1:0] cnt_t;

  // Spans count from zero, so n cycles end at n-1
  function automatic cnt_t last_count(input int n);
    return cnt_t'(n - 1);
  endfunction

  function automatic logic op_is_token(input dp_host_pkg::op_t op);
    return (op == dp_host_pkg::OP_TOKEN_RD) || (op == dp_host_pkg::OP_TOKEN_WR);
  endfunction

  function automatic logic op_is_wr(input dp_host_pkg::op_t op);
    return (op == dp_host_pkg::OP_MEM_WR) || (op == dp_host_pkg::OP_TOKEN_WR);
  endfunction

  // Data bits cross one by one; they are only taken after standing still for the whole strobe
  pin_sample_if smp ();

  pin_sampler u_sampler (
    .clock_i (clock_i),
    .rst_b_i (rst_b_i),
    .smp     (smp.sampler)
  );

  assign smp.flag_raw = port_collision_flag_n_i;
  assign smp.data_raw = data_i;

  dp_host_pkg::state_t state_ff;
  dp_host_pkg::state_t nxt_state;
  cnt_t                cnt_ff;
  cnt_t                nxt_cnt;
  dp_host_pkg::op_t    op_ff;
  dp_host_pkg::op_t    op_now;
  logic                accept;
  logic                strobe_on;
  logic                select_on;
  logic                mem_wr;

  assign accept    = (state_ff == dp_host_pkg::ST_IDLE) && cmd_valid_i;
  assign op_now    = accept ? cmd_op_i : op_ff;
  assign mem_wr    = (op_ff == dp_host_pkg::OP_MEM_WR);
  assign select_on = (nxt_state != dp_host_pkg::ST_IDLE) && (nxt_state != dp_host_pkg::ST_DONE);
  assign strobe_on = (nxt_state == dp_host_pkg::ST_STROBE) || (nxt_state == dp_host_pkg::ST_WAIT_FREE)
                     || (nxt_state == dp_host_pkg::ST_HOLD);

  // Sequencing of one access
  always_comb begin
    nxt_state = state_ff;
    nxt_cnt   = cnt_t'(cnt_ff + cnt_t'(1));
    unique case (state_ff)
      dp_host_pkg::ST_IDLE: begin
        nxt_cnt = '0;
        if (cmd_valid_i) begin
          nxt_state = dp_host_pkg::ST_SETUP;
        end
      end
      dp_host_pkg::ST_SETUP: begin
        // Address and enable settle, and the flag has time to show through the sampler
        if (cnt_ff == last_count(dp_host_pkg::SETTLE_CYC)) begin
          nxt_state = dp_host_pkg::ST_STROBE;
          nxt_cnt   = '0;
        end
      end
      dp_host_pkg::ST_STROBE: begin
        // Only memory writes wait: the memory gates writes, never reads, on a flagged port
        if (mem_wr && !smp.flag_sync) begin
          nxt_state = dp_host_pkg::ST_WAIT_FREE;
          nxt_cnt   = '0;
        end else if (cnt_ff == last_count(op_is_wr(op_ff) ? dp_host_pkg::ACCESS_CYC
                                                             : dp_host_pkg::READ_CYC)) begin
          nxt_state = dp_host_pkg::ST_DONE;
        end
      end
      dp_host_pkg::ST_WAIT_FREE: begin
        // Strobe stays asserted; the write lands only once the flag is high again
        nxt_cnt = '0;
        if (smp.flag_sync) begin
          nxt_state = dp_host_pkg::ST_HOLD;
        end
      end
      dp_host_pkg::ST_HOLD: begin
        if (cnt_ff == last_count(dp_host_pkg::HOLD_CYC)) begin
          nxt_state = dp_host_pkg::ST_DONE;
        end
      end
      dp_host_pkg::ST_DONE: begin
        nxt_state = dp_host_pkg::ST_IDLE;
      end
      default: begin
        nxt_state = dp_host_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_ff <= dp_host_pkg::ST_IDLE;
      cnt_ff   <= '0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff   <= nxt_cnt;
    end
  end

  // Pin drive; every access ends with enable, select and output enable released
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      op_ff                  <= dp_host_pkg::OP_MEM_RD;
      ce_n_o                 <= 1'h1;
      token_space_select_n_o <= 1'h1;
      rw_n_o                 <= 1'h1;
      oe_n_o                 <= 1'h1;
      addr_o                 <= '0;
      data_o                 <= dp_host_pkg::DATA_RST;
      data_oe_o              <= 1'h0;
    end else begin
      if (accept) begin
        op_ff  <= cmd_op_i;
        data_o <= cmd_wdata_i;
        // Semaphore space decodes only the low address bits; upper bits held at zero
        addr_o <= op_is_token(cmd_op_i)
                  ? {{(dp_host_pkg::ADDR_W-dp_host_pkg::TOKEN_SEL_W){1'b0}}, cmd_addr_i[dp_host_pkg::TOKEN_SEL_W-1:0]}
                  : cmd_addr_i;
      end
      ce_n_o                 <= !(select_on && !op_is_token(op_now));
      token_space_select_n_o <= !(select_on && op_is_token(op_now));
      rw_n_o                 <= !(strobe_on && op_is_wr(op_now));
      // Dropping the output enable after each read frees the latched semaphore value
      oe_n_o                 <= !(strobe_on && !op_is_wr(op_now));
      data_oe_o              <= select_on && op_is_wr(op_now);
    end
  end

  // Flag pin: input in master mode, driven in slave mode, low (inhibit) only while write_block_i is high
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      port_collision_flag_oe_o <= 1'h0;
      port_collision_flag_n_o  <= dp_host_pkg::FLAG_IDLE;
    end else begin
      // Never driven in master mode: the memory's push-pull driver owns the pin then
      port_collision_flag_oe_o <= slave_mode_i;
      port_collision_flag_n_o  <= !write_block_i;
    end
  end

  // Answers to the user side
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cmd_ready_o    <= 1'h0;
      rsp_valid_o    <= 1'h0;
      rsp_rdata_o    <= dp_host_pkg::DATA_RST;
      rsp_collided_o <= 1'h0;
    end else begin
      cmd_ready_o <= (nxt_state == dp_host_pkg::ST_IDLE);
      rsp_valid_o <= (nxt_state == dp_host_pkg::ST_DONE);
      // The collision mark is a report only; the write itself already waited for the flag
      if (accept) begin
        rsp_collided_o <= 1'h0;
      end else if (nxt_state == dp_host_pkg::ST_WAIT_FREE) begin
        rsp_collided_o <= 1'h1;
      end
      if ((state_ff == dp_host_pkg::ST_STROBE) && (nxt_state == dp_host_pkg::ST_DONE) && !op_is_wr(op_ff)) begin
        rsp_rdata_o <= smp.data_sync;
      end
    end
  end
endmodule

// ===== test/dp_port_host_checker.sv
// Checker for the host port: pin sequencing and flag pin handling.
// Assumes it is bound to dp_port_host and sees only its ports.
`timescale 1ns/100ps
module dp_port_host_checker (
  input wire logic        clock_i,
  input wire logic        rst_b_i,
  input wire logic        slave_mode_i,
  input wire logic        write_block_i,
  input wire logic        rsp_valid_o,
  input wire logic        rsp_collided_o,
  input wire logic        ce_n_o,
  input wire logic        token_space_select_n_o,
  input wire logic        rw_n_o,
  input wire logic        oe_n_o,
  input wire logic [13:0] addr_o,
  input wire logic        data_oe_o,
  input wire logic        port_collision_flag_n_i,
  input wire logic        port_collision_flag_n_o,
  input wire logic        port_collision_flag_oe_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_b_i);
  token_select_a: assert property (!token_space_select_n_o |-> ce_n_o && addr_o[13:3] == 11'h000)
    else $error("semaphore select with memory enable or high address");
  write_stall_a: assert property ((!ce_n_o && !rw_n_o && !port_collision_flag_n_i) [*4] |=> !rw_n_o)
    else $error("write strobe released while flag low");
  write_hold_a: assert property ($rose(rw_n_o) && rsp_collided_o |-> $past(port_collision_flag_n_i, 4))
    else $error("write strobe released too soon after flag");
  flag_dir_a: assert property (1'b1 |=> port_collision_flag_oe_o == $past(slave_mode_i))
    else $error("flag drive enable does not follow mode");
  flag_level_a: assert property (1'b1 |=> port_collision_flag_n_o == !$past(write_block_i))
    else $error("flag drive level does not follow write block");
  read_window_a: assert property ($fell(oe_n_o) |-> (rw_n_o && !data_oe_o && !oe_n_o) [*4]
    ##1 (oe_n_o && rsp_valid_o))
    else $error("read strobe shape wrong");
  write_drive_a: assert property (!rw_n_o |-> data_oe_o && !(ce_n_o && token_space_select_n_o))
    else $error("write strobe without data or select");
  write_len_a: assert property ($rose(rw_n_o) |-> rsp_valid_o && !$past(rw_n_o, 2))
    else $error("write strobe too short or unanswered");
endmodule
bind dp_port_host dp_port_host_checker chk (.clock_i, .rst_b_i, .slave_mode_i, .write_block_i, .rsp_valid_o,
  .rsp_collided_o, .ce_n_o, .token_space_select_n_o, .rw_n_o, .oe_n_o, .addr_o, .data_oe_o,
  .port_collision_flag_n_i, .port_collision_flag_n_o, .port_collision_flag_oe_o);

// ===== test/dp_mem_model.sv
// Behavioural model of one port of the two-port memory with semaphores.
// Assumes the bench plays the opposite port through collide_i and token_wr.
`timescale 1ns/100ps
module dp_mem_model (
  input  wire logic        ce_n_i,
  input  wire logic        token_n_i,
  input  wire logic        rw_n_i,
  input  wire logic        oe_n_i,
  input  wire logic [13:0] addr_i,
  input  wire logic [15:0] data_i,
  input  wire logic        flag_w_i,
  input  wire logic        collide_i,
  input  wire logic        master_i,
  output logic             flag_n_o,
  output logic      [15:0] data_o
);
  logic [15:0] mem [16];
  logic [15:0] val = 16'h0000;
  logic [15:0] wd;
  logic [13:0] wa;
  logic        w_ce, w_token;
  logic [7:0]  own [2] = '{default: 8'h00};
  logic [7:0]  req [2] = '{default: 8'h00};
  task automatic token_wr(input int s, input int i, input logic b);
    if (!b) begin
      if (!own[0][i] && !own[1][i]) own[s][i] = 1'b1;
      else if (!own[s][i]) req[s][i] = 1'b1;
    end else begin
      req[s][i] = 1'b0;
      if (own[s][i]) begin
        own[s][i] = 1'b0;
        own[1-s][i] = req[1-s][i];
        req[1-s][i] = 1'b0;
      end
    end
  endtask
  // Opposite port arrived first, so this port is the flagged one
  assign flag_n_o = !(master_i && collide_i && !ce_n_i);
  // A released bus shows the inverse of the last value, never a stale match
  assign data_o = (!oe_n_i && !(ce_n_i && token_n_i)) ? val : ~val;
  always @(negedge rw_n_i) begin
    w_ce <= !ce_n_i;
    w_token <= !token_n_i;
    wa <= addr_i;
    wd <= data_i;
  end
  always @(posedge rw_n_i) begin
    if (w_ce && flag_w_i) mem[wa[3:0]] <= wd;
    if (w_token) token_wr(0, wa[2:0], wd[0]);
  end
  always @(negedge oe_n_i) val <= !ce_n_i ? mem[addr_i[3:0]] : {16{!own[0][addr_i[2:0]]}};
endmodule

// ===== test/dp_port_host_tb.sv
// Self-checking bench for dp_port_host against a model of the memory port.
// Assumes a 25 MHz clock; inputs change at the falling edge.
`timescale 1ns/100ps
module dp_port_host_tb;
  logic             clock_i = 1'b0;
  logic             rst_b_i = 1'b0;
  logic             cmd_valid_i = 1'b0;
  dp_host_pkg::op_t cmd_op_i = dp_host_pkg::OP_MEM_RD;
  logic [13:0]      cmd_addr_i = 14'h0000;
  logic [15:0]      cmd_wdata_i = 16'h0000;
  logic             slave_mode_i = 1'b0;
  logic             write_block_i = 1'b0;
  logic             collide = 1'b0;
  logic             cmd_ready_o, rsp_valid_o, rsp_collided_o, ce_n_o, token_space_select_n_o, rw_n_o, oe_n_o;
  logic             data_oe_o, port_collision_flag_n_o, port_collision_flag_oe_o, mdl_flag;
  logic [13:0]      addr_o;
  logic [15:0]      rsp_rdata_o, data_o, data_i, mdl_data;
  logic             port_collision_flag_n_i;
  int               error_cnt = 0;
  int               n_tests = 0;
  always #20 clock_i = ~clock_i;
  assign data_i = data_oe_o ? data_o : mdl_data;
  assign port_collision_flag_n_i = port_collision_flag_oe_o ? port_collision_flag_n_o : mdl_flag;
  dp_port_host dut (.clock_i, .rst_b_i, .cmd_valid_i, .cmd_ready_o, .cmd_op_i, .cmd_addr_i, .cmd_wdata_i,
    .slave_mode_i, .write_block_i, .rsp_valid_o, .rsp_rdata_o, .rsp_collided_o, .ce_n_o, .token_space_select_n_o,
    .rw_n_o, .oe_n_o, .addr_o, .data_o, .data_oe_o, .data_i, .port_collision_flag_n_i, .port_collision_flag_n_o,
    .port_collision_flag_oe_o);
  dp_mem_model mdl (.ce_n_i(ce_n_o), .token_n_i(token_space_select_n_o), .rw_n_i(rw_n_o), .oe_n_i(oe_n_o),
    .addr_i(addr_o), .data_i(data_o), .flag_w_i(port_collision_flag_n_i), .collide_i(collide),
    .master_i(!slave_mode_i), .flag_n_o(mdl_flag), .data_o(mdl_data));
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      error_cnt++;
    end
  endtask
  task automatic op(input dp_host_pkg::op_t o, input logic [13:0] a, input logic [15:0] d);
    int k;
    @(negedge clock_i);
    chk(cmd_ready_o, 1'b1);
    cmd_op_i = o;
    cmd_addr_i = a;
    cmd_wdata_i = d;
    cmd_valid_i = 1'b1;
    @(negedge clock_i);
    cmd_valid_i = 1'b0;
    k = 0;
    while (rsp_valid_o !== 1'b1 && k < 300) begin
      @(negedge clock_i);
      k++;
    end
    chk(rsp_valid_o, 1'b1);
    if (rsp_valid_o !== 1'b1) finish_test();
  endtask
  task automatic t_mem();
    op(dp_host_pkg::OP_MEM_WR, 14'h3fff, 16'ha5c3);
    op(dp_host_pkg::OP_MEM_WR, 14'h0000, 16'h5a3c);
    op(dp_host_pkg::OP_MEM_RD, 14'h3fff, 16'h0000);
    chk(rsp_rdata_o, 16'ha5c3);
    chk(rsp_collided_o, 1'b0);
    op(dp_host_pkg::OP_MEM_RD, 14'h0000, 16'h0000);
    chk(rsp_rdata_o, 16'h5a3c);
    $display("t_mem done");
  endtask
  // Write meets a low flag, then is released; a read under the flag still works
  task automatic t_collide();
    collide = 1'b1;
    fork
      op(dp_host_pkg::OP_MEM_WR, 14'h0002, 16'h1234);
      begin
        repeat (20) @(negedge clock_i);
        collide = 1'b0;
      end
    join
    chk(rsp_collided_o, 1'b1);
    collide = 1'b1;
    op(dp_host_pkg::OP_MEM_RD, 14'h0002, 16'h0000);
    chk(rsp_rdata_o, 16'h1234);
    chk(rsp_collided_o, 1'b0);
    collide = 1'b0;
    $display("t_collide done");
  endtask
  task automatic t_slave();
    slave_mode_i = 1'b1;
    write_block_i = 1'b1;
    repeat (3) @(negedge clock_i);
    chk(port_collision_flag_n_i, 1'b0);
    fork
      op(dp_host_pkg::OP_MEM_WR, 14'h0004, 16'h0f0f);
      begin
        repeat (20) @(negedge clock_i);
        write_block_i = 1'b0;
      end
    join
    chk(rsp_collided_o, 1'b1);
    op(dp_host_pkg::OP_MEM_RD, 14'h0004, 16'h0000);
    chk(rsp_rdata_o, 16'h0f0f);
    slave_mode_i = 1'b0;
    $display("t_slave done");
  endtask
  // Ownership walk on the top semaphore; the far side writes through the model
  task automatic t_token();
    logic [0:9] sd, bt, el;
    sd = 10'h12c;
    bt = 10'h0b5;
    el = 10'h0dd;
    for (int i = 0; i < 8; i++) begin
      op(dp_host_pkg::OP_TOKEN_RD, 14'(i), 16'h0000);
      chk(rsp_rdata_o, 16'hffff);
    end
    for (int i = 0; i < 10; i++) begin
      if (sd[i]) mdl.token_wr(1, 7, bt[i]);
      else op(dp_host_pkg::OP_TOKEN_WR, 14'h3fff, {15'h7fff, bt[i]});
      op(dp_host_pkg::OP_TOKEN_RD, 14'h3fff, 16'h0000);
      chk(rsp_rdata_o, {16{el[i]}});
    end
    $display("t_token done");
  endtask
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge clock_i);
    @(negedge clock_i);
    chk({ce_n_o, token_space_select_n_o, rw_n_o, oe_n_o, cmd_ready_o, data_oe_o}, 6'h3c);
    rst_b_i = 1'b1;
    t_mem();
    t_collide();
    t_slave();
    t_token();
    finish_test();
  end
  // About fourteen times the expected run
  initial begin
    #200000;
    error_cnt++;
    finish_test();
  end
endmodule
